// ==== design/irq_pkg.sv ====
// Package of the interrupt, event transfer and trap controller.
// Assumes one CPU clock domain shared with the core and peripherals.
package irq_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int SRC_COUNT = 59;
  localparam int PET_CHANNELS = 8;
  localparam int LEVEL_W = 4;
  localparam int EXT_COUNT = 8;
  localparam int EXT_SRC_BASE = 0;
  localparam int TRAP_COUNT = 8;

  // ----------------------------------------------------------------
  // Trap cause flag positions, class A first in priority order
  // ----------------------------------------------------------------
  localparam int NMI_BIT = 0;
  localparam int STACK_OVER_BIT = 1;
  localparam int STACK_UNDER_BIT = 2;
  localparam int CLASS_B_FIRST = 3;

  // ----------------------------------------------------------------
  // Trap numbers; every vector is the number times four
  // ----------------------------------------------------------------
  localparam logic [6:0] NONMASKABLE_NUM = 7'h02;
  localparam logic [6:0] STACK_OVER_NUM = 7'h04;
  localparam logic [6:0] STACK_UNDER_NUM = 7'h06;
  localparam logic [6:0] CLASS_B_NUM = 7'h0a;
  localparam logic [6:0] SRC_NUM_BASE = 7'h10;

  // ----------------------------------------------------------------
  // Reset values and codes
  // ----------------------------------------------------------------
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [1:0] CLS_NONE = 2'h0;
  localparam logic [1:0] CLS_B = 2'h1;
  localparam logic [1:0] CLS_A = 2'h2;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;

  typedef struct packed {
    logic enable;
    logic [LEVEL_W-1:0] level;
    logic use_pet;
    logic [2:0] chan;
  } src_cfg_t;

  typedef struct packed {
    logic [15:0] src_ptr;
    logic [15:0] dst_ptr;
    logic [7:0] count;
    logic word;
    logic inc_dst;
    logic cont;
  } pet_cfg_t;

  typedef struct packed {
    logic [15:0] src_addr;
    logic [15:0] dst_addr;
    logic word;
  } xfer_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_INT = 2'b01,
    ST_TRAP = 2'b10
  } state_t;

endpackage

// ==== design/fast_edge_detect.sv ====
// Synchronised edge detector for one fast external request input.
// Assumes the pin is asynchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module fast_edge_detect
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Pin and edge selection
  input wire logic pin,
  input wire logic [1:0] edge_sel,
  // Event pulse
  output logic event_q
);

  logic sync1_q, sync2_q, last_q, event_d;

  // ----------------------------------------------------------------
  // Edge decode
  // ----------------------------------------------------------------
  // Only sync2_q and last_q are compared, never the first stage.
  always_comb
  begin
    event_d = 1'b0;
    if (edge_sel[0] && sync2_q && !last_q)
      event_d = 1'b1;
    if (edge_sel[1] && !sync2_q && last_q)
      event_d = 1'b1;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      last_q <= 1'b0;
      event_q <= 1'b0;
    end
    else
    begin
      sync1_q <= pin;
      sync2_q <= sync1_q;
      last_q <= sync2_q;
      event_q <= event_d;
    end
  end

endmodule // fast_edge_detect
`default_nettype wire

// ==== design/irq_controller.sv ====
// Interrupt arbiter, peripheral event transfer engine and trap unit.
// Assumes peripheral and core inputs are on clk; fast pins are not.
// How it works
// - service starts 5 to 12 clocks after request; here the offer or transfer comes 1 clock after the request bit sets
// - each source routed vectored or event transfer
// - vectored branches; event transfer steals one cycle
// - transfer moves byte/word, bumps source or destination
// - counter decrements per service, held when continuous
// - zero counter raises source vectored interrupt instead
// - eight channels with own pointers and counter
// - per source request, enable and level bits
// - sixteen priority levels arbitrate pending requests
// - preempt only for strictly higher level
// - each source has its own vector
// - fast inputs detect rising, falling or both edges
// - up to 59 sources, inputs sampled each clock
// - trap instruction enters chosen trap number
// - software set of request bit is pending request
// - runtime exception gives non-maskable vectored trap
// - each trap sets its cause flag
// - trap interrupts unless equal or higher trap class in service
// - trap service blocks vectored interrupts and event transfers, but not a pending trap instruction
// - class A traps use their own fixed vectors
// - class B traps share one vector and number
// - trap instruction numbers to 7f, vector times four
`timescale 1ns/1ps
`default_nettype none
module irq_controller
#(
  parameter int NUM_SRC = irq_pkg::SRC_COUNT,
  parameter int NUM_CH = irq_pkg::PET_CHANNELS,
  parameter int NUM_EXT = irq_pkg::EXT_COUNT
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Request sources
  input wire logic [NUM_SRC-1:0] periph_req,
  input wire logic [NUM_EXT-1:0] ext_pin,
  input wire logic [1:0] ext_edge_sel [NUM_EXT],
  // Software control of sources
  input wire irq_pkg::src_cfg_t src_cfg [NUM_SRC],
  input wire logic [NUM_SRC-1:0] sw_set_req,
  input wire logic [NUM_SRC-1:0] sw_clr_req,
  // Event transfer channel loading
  input wire logic pet_load,
  input wire logic [2:0] pet_load_chan,
  input wire irq_pkg::pet_cfg_t pet_load_cfg,
  // CPU side
  input wire logic [3:0] cpu_level,
  input wire logic int_ack,
  input wire logic trap_ack,
  input wire logic trap_done,
  input wire logic sw_trap_valid,
  input wire logic [6:0] sw_trap_num,
  input wire logic [irq_pkg::TRAP_COUNT-1:0] trap_event,
  input wire logic [irq_pkg::TRAP_COUNT-1:0] trap_flag_clr,
  // Vectored request out
  output logic int_req_q,
  output logic [6:0] int_num_q,
  output logic [8:0] int_vec_q,
  output logic [3:0] int_level_q,
  // Trap request out
  output logic trap_req_q,
  output logic [6:0] trap_num_q,
  output logic [8:0] trap_vec_q,
  output logic [1:0] trap_cls_q,
  // Event transfer out
  output logic pet_valid_q,
  output logic [2:0] pet_chan_q,
  output irq_pkg::xfer_t pet_xfer_q,
  output irq_pkg::pet_cfg_t pet_state_q [NUM_CH],
  // Status
  output logic [NUM_SRC-1:0] source_request_bit_q,
  output logic [irq_pkg::TRAP_COUNT-1:0] trap_cause_flags_q
);

  localparam int LAT_MAX = 12;
  localparam int SRC_W = $clog2(NUM_SRC);

  // ----------------------------------------------------------------
  // Fast external inputs
  // ----------------------------------------------------------------
  logic [NUM_EXT-1:0] ext_event;
  logic [NUM_SRC-1:0] ext_set;

  generate
    for (genvar e = 0; e < NUM_EXT; e++)
    begin : g_ext
      fast_edge_detect u_edge
      (
        .clk(clk),
        .rst_n(rst_n),
        .pin(ext_pin[e]),
        .edge_sel(ext_edge_sel[e]),
        .event_q(ext_event[e])
      );
    end
  endgenerate

  always_comb
  begin
    ext_set = '0;
    for (int e = 0; e < NUM_EXT; e++)
      ext_set[irq_pkg::EXT_SRC_BASE + e] = ext_event[e];
  end

  // ----------------------------------------------------------------
  // Trap helpers
  // ----------------------------------------------------------------
  function automatic logic [1:0] trap_class(input logic [2:0] idx);
    if (idx < 3'(irq_pkg::CLASS_B_FIRST))
      trap_class = irq_pkg::CLS_A;
    else
      trap_class = irq_pkg::CLS_B;
  endfunction

  function automatic logic [6:0] trap_number(input logic [2:0] idx);
    case (idx)
      3'(irq_pkg::NMI_BIT): trap_number = irq_pkg::NONMASKABLE_NUM;
      3'(irq_pkg::STACK_OVER_BIT): trap_number = irq_pkg::STACK_OVER_NUM;
      3'(irq_pkg::STACK_UNDER_BIT): trap_number = irq_pkg::STACK_UNDER_NUM;
      default: trap_number = irq_pkg::CLASS_B_NUM;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  irq_pkg::state_t st_q, st_d;
  logic [NUM_SRC-1:0] req_d;
  logic [7:0] flags_d, tpend_q, tpend_d;
  logic [1:0] tcls_d;
  logic [2:0] tsel_q, tsel_d;
  logic swt_pend_q, swt_pend_d;
  logic [6:0] swt_num_q, swt_num_d;
  logic [SRC_W-1:0] isel_q, isel_d;
  logic int_sw_q, int_sw_d;
  logic int_req_d, trap_req_d, pet_valid_d;
  logic [6:0] int_num_d, trap_num_d;
  logic [3:0] int_level_d;
  logic [2:0] pet_chan_d;
  irq_pkg::xfer_t pet_xfer_d;
  irq_pkg::pet_cfg_t pet_d [NUM_CH];

  // Arbitration and trap selection.
  logic win_found;
  logic [SRC_W-1:0] win_idx;
  logic [3:0] win_lv;
  logic [2:0] tpick;
  logic trap_go;
  irq_pkg::src_cfg_t wcfg;
  irq_pkg::pet_cfg_t wch;

  always_comb
  begin
    win_found = 1'b0;
    win_idx = '0;
    win_lv = '0;
    // Strict compare keeps the lowest index on a tie.
    for (int i = 0; i < NUM_SRC; i++)
      if (source_request_bit_q[i] && src_cfg[i].enable &&
          src_cfg[i].level > cpu_level &&
          (!win_found || src_cfg[i].level > win_lv))
      begin
        win_found = 1'b1;
        win_idx = SRC_W'(i);
        win_lv = src_cfg[i].level;
      end
    tpick = 3'd0;
    for (int t = irq_pkg::TRAP_COUNT - 1; t >= 0; t--)
      if (tpend_q[t])
        tpick = 3'(t);
    // A trap waits only behind an equal or higher trap class.
    trap_go = (|tpend_q) && trap_class(tpick) > trap_cls_q;
    wcfg = src_cfg[win_idx];
    wch = pet_state_q[wcfg.chan];
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_d = st_q;
    req_d = source_request_bit_q & ~sw_clr_req;
    flags_d = trap_cause_flags_q & ~trap_flag_clr;
    tpend_d = tpend_q;
    tcls_d = trap_cls_q;
    tsel_d = tsel_q;
    swt_pend_d = swt_pend_q;
    swt_num_d = swt_num_q;
    isel_d = isel_q;
    int_sw_d = int_sw_q;
    int_req_d = int_req_q;
    int_num_d = int_num_q;
    int_level_d = int_level_q;
    trap_req_d = trap_req_q;
    trap_num_d = trap_num_q;
    pet_valid_d = 1'b0;
    pet_chan_d = pet_chan_q;
    pet_xfer_d = pet_xfer_q;
    pet_d = pet_state_q;
    if (pet_load)
      pet_d[pet_load_chan] = pet_load_cfg;
    if (sw_trap_valid)
    begin
      swt_pend_d = 1'b1;
      swt_num_d = sw_trap_num;
    end
    case (st_q)
      irq_pkg::ST_IDLE:
      begin
        if (trap_go)
        begin
          st_d = irq_pkg::ST_TRAP;
          trap_req_d = 1'b1;
          tsel_d = tpick;
          trap_num_d = trap_number(tpick);
        end
        else if (swt_pend_q)
        begin
          // Runs at the current CPU level, even inside a trap.
          st_d = irq_pkg::ST_INT;
          int_req_d = 1'b1;
          int_sw_d = 1'b1;
          int_num_d = swt_num_q;
          int_level_d = cpu_level;
        end
        else if (win_found && trap_cls_q == irq_pkg::CLS_NONE)
        begin
          if (wcfg.use_pet && (wch.cont || wch.count != 8'h00))
          begin
            pet_valid_d = 1'b1;
            pet_chan_d = wcfg.chan;
            pet_xfer_d.src_addr = wch.src_ptr;
            pet_xfer_d.dst_addr = wch.dst_ptr;
            pet_xfer_d.word = wch.word;
            if (wch.inc_dst)
              pet_d[wcfg.chan].dst_ptr = wch.dst_ptr +
                (wch.word ? 16'h0002 : 16'h0001);
            else
              pet_d[wcfg.chan].src_ptr = wch.src_ptr +
                (wch.word ? 16'h0002 : 16'h0001);
            if (!wch.cont)
              pet_d[wcfg.chan].count = wch.count - 8'h01;
            req_d[win_idx] = 1'b0;
          end
          else
          begin
            st_d = irq_pkg::ST_INT;
            int_req_d = 1'b1;
            int_sw_d = 1'b0;
            isel_d = win_idx;
            int_num_d = irq_pkg::SRC_NUM_BASE + 7'(win_idx);
            int_level_d = win_lv;
          end
        end
      end
      irq_pkg::ST_INT:
      begin
        if (trap_go)
        begin
          // Withdraw the offer; the source stays pending.
          st_d = irq_pkg::ST_TRAP;
          int_req_d = 1'b0;
          trap_req_d = 1'b1;
          tsel_d = tpick;
          trap_num_d = trap_number(tpick);
        end
        else if (int_ack)
        begin
          st_d = irq_pkg::ST_IDLE;
          int_req_d = 1'b0;
          if (int_sw_q)
            swt_pend_d = sw_trap_valid;
          else
            req_d[isel_q] = 1'b0;
        end
      end
      irq_pkg::ST_TRAP:
      begin
        if (trap_ack)
        begin
          st_d = irq_pkg::ST_IDLE;
          trap_req_d = 1'b0;
          tcls_d = trap_class(tsel_q);
          if (trap_class(tsel_q) == irq_pkg::CLS_B)
            tpend_d[7:3] = 5'h00;
          else
            tpend_d[tsel_q] = 1'b0;
        end
      end
      default:
      begin
        st_d = irq_pkg::ST_IDLE;
      end
    endcase
    if (trap_done)
      tcls_d = irq_pkg::CLS_NONE;
    // Sets after clears, so a same-cycle event is never lost.
    req_d = req_d | periph_req | ext_set | sw_set_req;
    flags_d = flags_d | trap_event;
    tpend_d = tpend_d | trap_event;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q <= irq_pkg::ST_IDLE;
      source_request_bit_q <= '0;
      trap_cause_flags_q <= irq_pkg::FLAGS_RESET;
      tpend_q <= irq_pkg::FLAGS_RESET;
      trap_cls_q <= irq_pkg::CLS_NONE;
      tsel_q <= 3'h0;
      swt_pend_q <= 1'b0;
      swt_num_q <= 7'h00;
      isel_q <= '0;
      int_sw_q <= 1'b0;
      int_req_q <= 1'b0;
      int_num_q <= 7'h00;
      int_vec_q <= 9'h000;
      int_level_q <= 4'h0;
      trap_req_q <= 1'b0;
      trap_num_q <= 7'h00;
      trap_vec_q <= 9'h000;
      pet_valid_q <= 1'b0;
      pet_chan_q <= 3'h0;
      pet_xfer_q <= '0;
      for (int c = 0; c < NUM_CH; c++)
        pet_state_q[c] <= '0;
    end
    else
    begin
      st_q <= st_d;
      source_request_bit_q <= req_d;
      trap_cause_flags_q <= flags_d;
      tpend_q <= tpend_d;
      trap_cls_q <= tcls_d;
      tsel_q <= tsel_d;
      swt_pend_q <= swt_pend_d;
      swt_num_q <= swt_num_d;
      isel_q <= isel_d;
      int_sw_q <= int_sw_d;
      int_req_q <= int_req_d;
      int_num_q <= int_num_d;
      int_vec_q <= {int_num_d, 2'b00};
      int_level_q <= int_level_d;
      trap_req_q <= trap_req_d;
      trap_num_q <= trap_num_d;
      trap_vec_q <= {trap_num_d, 2'b00};
      pet_valid_q <= pet_valid_d;
      pet_chan_q <= pet_chan_d;
      pet_xfer_q <= pet_xfer_d;
      pet_state_q <= pet_d;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  int_latency_a: assert property (@(posedge clk) disable iff (!rst_n)
    (st_q == irq_pkg::ST_IDLE && win_found && !trap_go && !swt_pend_q &&
     trap_cls_q == irq_pkg::CLS_NONE && !pet_valid_d)
    |-> ##[1:LAT_MAX] int_req_q)
    else $error("standard request not offered in time");
  pet_one_cycle_a: assert property (@(posedge clk) disable iff (!rst_n)
    pet_valid_q |-> !int_req_q && $past(st_q) == irq_pkg::ST_IDLE)
    else $error("transfer slot outside idle");
  pet_count_a: assert property (@(posedge clk) disable iff (!rst_n)
    pet_valid_d && !pet_load && !wch.cont
    |=> pet_state_q[pet_chan_q].count ==
        $past(wch.count) - 8'h01)
    else $error("transfer count not decremented");
  trap_blocks_a: assert property (@(posedge clk) disable iff (!rst_n)
    trap_cls_q != irq_pkg::CLS_NONE && !swt_pend_q
    |=> !pet_valid_q && !$rose(int_req_q))
    else $error("interrupt taken during trap service");
  level_higher_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(int_req_q) && !int_sw_q |-> int_level_q > $past(cpu_level))
    else $error("request level not above cpu level");
  int_vector_a: assert property (@(posedge clk) disable iff (!rst_n)
    int_req_q && !int_sw_q
    |-> int_num_q == irq_pkg::SRC_NUM_BASE + 7'(isel_q) &&
        int_vec_q == {int_num_q, 2'b00})
    else $error("source vector mismatch");
  trap_flag_set_a: assert property (@(posedge clk) disable iff (!rst_n)
    |trap_event |=> (trap_cause_flags_q & $past(trap_event)) ==
                    $past(trap_event))
    else $error("trap cause flag not set");
  trap_vector_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(trap_req_q) && tsel_q >= 3'(irq_pkg::CLASS_B_FIRST)
    |-> trap_num_q == irq_pkg::CLASS_B_NUM && trap_vec_q == 9'h028)
    else $error("class b trap vector wrong");
  sw_request_a: assert property (@(posedge clk) disable iff (!rst_n)
    |sw_set_req |=> (source_request_bit_q & $past(sw_set_req)) ==
                    $past(sw_set_req))
    else $error("software request lost");

endmodule // irq_controller
`default_nettype wire

// ==== tb/cpu_partner.sv ====
// CPU partner model: takes offered vectored requests and traps.
// Assumes each offer stands until acked and falls on the next edge.
`timescale 1ns/1ps
`default_nettype none
module cpu_partner
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Offers and pacing
  input wire logic [1:0] offer,
  input wire logic [3:0] ack_wait,
  // Acknowledge pulses
  output logic [1:0] ack
);
  logic [3:0] cnt_q [2];

  // A slow core lets ack_wait cycles pass before it takes an offer.
  always_ff @(posedge clk or negedge rst_n)
  begin
    for (int k = 0; k < 2; k++)
    begin
      if (!rst_n)
      begin
        ack[k] <= 1'b0;
        cnt_q[k] <= 4'h0;
      end
      else
      begin
        ack[k] <= offer[k] && !ack[k] && cnt_q[k] == ack_wait;
        if (offer[k] && !ack[k] && cnt_q[k] != ack_wait)
          cnt_q[k] <= cnt_q[k] + 4'h1;
        else
          cnt_q[k] <= 4'h0;
      end
    end
  end
endmodule // cpu_partner
`default_nettype wire

// ==== tb/irq_controller_tb.sv ====
// Self-checking bench for irq_controller with a CPU partner model.
// Assumes a 20 MHz clock; inputs change 1 ns after each rising edge.
`timescale 1ns/1ps
`default_nettype none
module irq_controller_tb;
  logic clk, rst_n, pet_load, sw_trap_valid, trap_done;
  logic int_req_q, trap_req_q, pet_valid_q;
  logic [58:0] periph_req, sw_set_req, sw_clr_req, source_request_bit_q;
  logic [7:0] ext_pin, trap_event, trap_flag_clr, trap_cause_flags_q;
  logic [1:0] ext_edge_sel [8];
  logic [1:0] trap_cls_q, acks;
  logic [2:0] pet_load_chan, pet_chan_q;
  logic [3:0] cpu_level, ack_wait, int_level_q;
  logic [6:0] sw_trap_num, int_num_q, trap_num_q;
  logic [8:0] int_vec_q, trap_vec_q;
  irq_pkg::src_cfg_t src_cfg [59];
  irq_pkg::pet_cfg_t pet_load_cfg, exp_c;
  irq_pkg::pet_cfg_t pet_state_q [8];
  irq_pkg::xfer_t pet_xfer_q;
  logic [31:0] seed;
  int n_fail = 0, checks = 0, cyc = 0, n, lat, i;

  irq_controller i_dut
  (
    .clk(clk), .rst_n(rst_n), .periph_req(periph_req),
    .ext_pin(ext_pin), .ext_edge_sel(ext_edge_sel), .src_cfg(src_cfg),
    .sw_set_req(sw_set_req), .sw_clr_req(sw_clr_req),
    .pet_load(pet_load), .pet_load_chan(pet_load_chan),
    .pet_load_cfg(pet_load_cfg), .cpu_level(cpu_level),
    .int_ack(acks[0]), .trap_ack(acks[1]), .trap_done(trap_done),
    .sw_trap_valid(sw_trap_valid), .sw_trap_num(sw_trap_num),
    .trap_event(trap_event), .trap_flag_clr(trap_flag_clr),
    .int_req_q(int_req_q), .int_num_q(int_num_q), .int_vec_q(int_vec_q),
    .int_level_q(int_level_q), .trap_req_q(trap_req_q),
    .trap_num_q(trap_num_q), .trap_vec_q(trap_vec_q),
    .trap_cls_q(trap_cls_q), .pet_valid_q(pet_valid_q),
    .pet_chan_q(pet_chan_q), .pet_xfer_q(pet_xfer_q),
    .pet_state_q(pet_state_q), .source_request_bit_q(source_request_bit_q),
    .trap_cause_flags_q(trap_cause_flags_q)
  );

  cpu_partner i_cpu
  (
    .clk(clk), .rst_n(rst_n), .offer({trap_req_q, int_req_q}),
    .ack_wait(ack_wait), .ack(acks)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic irq_pkg::pet_cfg_t pet_next(irq_pkg::pet_cfg_t c);
    logic [15:0] st;
    st = c.word ? 16'h0002 : 16'h0001;
    if (c.inc_dst)
      c.dst_ptr += st;
    else
      c.src_ptr += st;
    if (!c.cont)
      c.count -= 8'h01;
    return c;
  endfunction

  task automatic chk(input logic [63:0] got, exp, input string what);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error at %0t: %s got %0h expected %0h", $time, what, got,
               exp);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic wait_lvl(input logic trap, input logic lv, input int lim);
    n = 0;
    while ((trap ? trap_req_q : int_req_q) !== lv && n < lim)
    begin
      tick(1);
      n++;
    end
  endtask

  task automatic cfg(input int s, input logic en, input logic [3:0] lv,
                     input logic pet, input logic [2:0] ch);
    src_cfg[s] = '{en, lv, pet, ch};
  endtask

  task automatic pulse_src(input int s, input logic per);
    if (per)
      periph_req[s] = 1'b1;
    else
      sw_set_req[s] = 1'b1;
    tick(1);
    periph_req = '0;
    sw_set_req = '0;
  endtask

  task automatic exp_int(input logic [6:0] num, input logic [3:0] lv);
    wait_lvl(1'b0, 1'b1, 12);
    lat = n;
    chk(n < 12, 1, "int offer");
    chk(int_num_q, num, "int num");
    chk(int_vec_q, {num, 2'b00}, "int vector");
    chk(int_level_q, lv, "int level");
    wait_lvl(1'b0, 1'b0, 20);
  endtask

  task automatic exp_trap(input logic [6:0] num, input logic [1:0] cls);
    wait_lvl(1'b1, 1'b1, 8);
    lat = n;
    chk(trap_num_q, num, "trap num");
    chk(trap_vec_q, {num, 2'b00}, "trap vector");
    wait_lvl(1'b1, 1'b0, 20);
    chk(trap_cls_q, cls, "trap class");
  endtask

  task automatic end_trap(input logic clr);
    trap_done = 1'b1;
    trap_flag_clr = clr ? 8'hff : 8'h00;
    tick(1);
    trap_done = 1'b0;
    trap_flag_clr = 8'h00;
  endtask

  task automatic ext_try(input int k, input logic v, input logic e);
    ext_pin[k] = v;
    wait_lvl(1'b0, 1'b1, 10);
    chk(n < 10, e, "edge event");
    if (n < 10)
      chk(int_num_q, 7'h10 + 7'(k), "edge source");
    wait_lvl(1'b0, 1'b0, 20);
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // The whole run needs well under 3000 cycles.
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      n_fail++;
      $display("Error at %0t: timeout", $time);
      give_verdict();
    end
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial
  begin
    seed = 32'h0001_1711;
    rst_n = 1'b0;
    {periph_req, sw_set_req, sw_clr_req} = '0;
    {ext_pin, trap_event, trap_flag_clr} = '0;
    {pet_load, sw_trap_valid, trap_done, pet_load_chan} = '0;
    {cpu_level, ack_wait, sw_trap_num} = '0;
    pet_load_cfg = '0;
    foreach (src_cfg[s]) src_cfg[s] = '0;
    foreach (ext_edge_sel[s]) ext_edge_sel[s] = 2'h0;
    repeat (12) @(posedge clk);
    #1;
    rst_n = 1'b1;
    tick(1);
    chk({int_req_q, trap_req_q, pet_valid_q, trap_cause_flags_q}, 0, "rst");
    for (int k = 0; k < 8; k++)
    begin
      i = k == 0 ? 58 : int'(rnd() % 59);
      lat = int'(rnd() % 15) + 1;
      ack_wait = 4'(rnd() % 4);
      cfg(i, 1'b1, 4'(lat), 1'b0, 3'h0);
      pulse_src(i, k[0]);
      chk(source_request_bit_q[i], 1, "req bit");
      exp_int(7'h10 + 7'(i), src_cfg[i].level);
      chk(lat, 1, "latency");
      chk(source_request_bit_q[i], 0, "req cleared");
    end
    $display("vectored test done");
    cfg(50, 1'b1, 4'h6, 1'b0, 3'h0);
    cpu_level = 4'h6;
    pulse_src(50, 1'b0);
    tick(4);
    chk(int_req_q, 0, "equal level");
    cfg(50, 1'b0, 4'h6, 1'b0, 3'h0);
    cpu_level = 4'h0;
    tick(4);
    chk(int_req_q, 0, "disabled");
    sw_clr_req[50] = 1'b1;
    tick(1);
    sw_clr_req = '0;
    chk(source_request_bit_q[50], 0, "sw clear");
    pulse_src(50, 1'b1);
    cfg(50, 1'b1, 4'h6, 1'b0, 3'h0);
    cpu_level = 4'h5;
    exp_int(7'h42, 4'h6);
    cpu_level = 4'h0;
    cfg(5, 1'b1, 4'h3, 1'b0, 3'h0);
    cfg(9, 1'b1, 4'h3, 1'b0, 3'h0);
    cfg(40, 1'b1, 4'h7, 1'b0, 3'h0);
    sw_set_req = 59'h100_0000_0220;
    tick(1);
    sw_set_req = '0;
    exp_int(7'h38, 4'h7);
    exp_int(7'h15, 4'h3);
    exp_int(7'h19, 4'h3);
    $display("priority test done");
    for (int c = 0; c < 8; c++)
    begin
      exp_c = '{16'(rnd()), 16'(rnd()), 8'h02, c[0], c[1], c == 7};
      pet_load = 1'b1;
      pet_load_chan = 3'(c);
      pet_load_cfg = exp_c;
      tick(1);
      pet_load = 1'b0;
      chk(pet_state_q[c], exp_c, "load");
      cfg(20 + c, 1'b1, 4'h5, 1'b1, 3'(c));
      for (int s = 0; s < 3; s++)
      begin
        pulse_src(20 + c, s[0]);
        tick(1);
        if (exp_c.count == 8'h00 && !exp_c.cont)
        begin
          chk(pet_valid_q, 0, "no xfer");
          exp_int(7'h10 + 7'(20 + c), 4'h5);
        end
        else
        begin
          chk(pet_valid_q, 1, "xfer");
          chk(pet_chan_q, c, "chan");
          chk(pet_xfer_q, {exp_c.src_ptr,exp_c.dst_ptr,exp_c.word}, "x");
          chk(int_req_q, 0, "no vector");
          exp_c = pet_next(exp_c);
          chk(pet_state_q[c], exp_c, "ptr count");
          tick(1);
          chk(pet_valid_q, 0, "one cycle");
        end
      end
    end
    $display("transfer test done");
    cfg(33, 1'b1, 4'h4, 1'b0, 3'h0);
    for (int t = 0; t < 8; t++)
    begin
      trap_event = 8'(1 << t);
      tick(1);
      trap_event = '0;
      chk(trap_cause_flags_q[t], 1, "flag");
      exp_trap(t < 3 ? 7'(2 * t + 2) : 7'h0a, t < 3 ? 2'h2 : 2'h1);
      chk(lat, 1, "trap latency");
      pulse_src(33, 1'b0);
      tick(3);
      chk(int_req_q, 0, "held off");
      end_trap(1'b1);
      chk(trap_cause_flags_q, 0, "flag clear");
      exp_int(7'h31, 4'h4);
    end
    trap_event = 8'h08;
    tick(1);
    trap_event = '0;
    exp_trap(7'h0a, 2'h1);
    trap_event = 8'h11;
    tick(1);
    trap_event = '0;
    exp_trap(7'h02, 2'h2);
    tick(4);
    chk(trap_req_q, 0, "b waits");
    end_trap(1'b0);
    exp_trap(7'h0a, 2'h1);
    end_trap(1'b1);
    $display("trap test done");
    for (int k = 0; k < 3; k++)
    begin
      cpu_level = 4'(rnd());
      sw_trap_num = k == 0 ? 7'h00 : k == 1 ? 7'h7f : 7'(rnd());
      sw_trap_valid = 1'b1;
      tick(1);
      sw_trap_valid = 1'b0;
      exp_int(sw_trap_num, cpu_level);
    end
    cpu_level = 4'h0;
    $display("software trap test done");
    for (int k = 0; k < 4; k++)
    begin
      ext_edge_sel[k] = 2'(k + 1);
      cfg(k, 1'b1, 4'h2, 1'b0, 3'h0);
      ext_try(k, 1'b1, ext_edge_sel[k][0]);
      ext_try(k, 1'b0, ext_edge_sel[k][1]);
    end
    $display("edge test done");
    give_verdict();
  end
endmodule // irq_controller_tb
`default_nettype wire
